/* File: src/wid_cfg.svh */
// constants for the wake-up and interrupt dispatch block
`ifndef WID_CFG_SVH
`define WID_CFG_SVH
`define WID_MODE_W 4
`define WID_MODE_SLEEP 4'h1
`define WID_MODE_IDLE 4'h2
`define WID_MODE_GREEN 4'h4
`define WID_MODE_NORMAL 4'h8
`define WID_NSRC 3
`define WID_SRC_PIN 0
`define WID_SRC_TWI 1
`define WID_SRC_SPI 2
`endif

/* File: src/wid_dispatch.sv */
// wake-up and interrupt dispatch controller
`timescale 1ns/1ns
`include "wid_cfg.svh"
module wid_dispatch
   import wid_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // power mode and global interrupt state from the core
   input wire logic [`WID_MODE_W-1:0] power_mode_i,
   input wire logic global_irq_enabled_i,
   // pin-change source
   input wire logic pin_change_evt_i,
   input wire logic pin_change_wake_en_i,
   input wire logic pin_change_irq_en_i,
   // two-wire serial source
   input wire logic twowire_evt_i,
   input wire logic twowire_wake_en_i,
   input wire logic twowire_irq_en_i,
   input wire logic twowire_slave_i,
   // serial peripheral source
   input wire logic serial_periph_evt_i,
   input wire logic serial_periph_wake_en_i,
   input wire logic serial_periph_irq_en_i,
   input wire logic serial_periph_slave_i,
   // watchdog
   input wire logic watchdog_timeout_i,
   // core sequencer side
   input wire logic vector_ack_i,
   output logic wake_o,
   output logic resume_o,
   output logic vector_req_o,
   output logic [`WID_NSRC-1:0] vector_src_o,
   output logic reset_req_o,
   output logic [3:0] action_o
);
   wid_mode_t mode;
   logic low_pwr;
   logic green;
   logic normal;
   logic [`WID_NSRC-1:0] wake_v;
   logic [`WID_NSRC-1:0] irq_v;
   logic any_wake;
   logic any_irq;
   logic nxt_vec;
   wid_action_t nxt_action;
   wid_action_t action_ff;
   logic vector_req_ff;
   logic [`WID_NSRC-1:0] vector_src_ff;
   logic [`WID_NSRC-1:0] nxt_src;
   logic wake_ff;
   logic resume_ff;
   logic reset_ff;
   logic nxt_wake;
   logic nxt_resume;
   logic nxt_reset;

   assign mode = wid_mode_t'(power_mode_i);

   // ----------------------------------------------------------------
   // power mode decode
   // ----------------------------------------------------------------
   always_comb begin
      low_pwr = 1'b0;
      green = 1'b0;
      normal = 1'b0;
      unique case (mode)
         WID_SLEEP, WID_IDLE: begin
            low_pwr = 1'b1;
         end
         WID_GREEN: begin
            green = 1'b1;
         end
         WID_NORMAL: begin
            normal = 1'b1;
         end
         default: begin
            // codes outside the one-hot set wake and interrupt nothing
            low_pwr = 1'b0;
         end
      endcase
   end

   wid_src_if pin_s ();
   wid_src_if twi_s ();
   wid_src_if spi_s ();

   // ----------------------------------------------------------------
   // source qualification
   // ----------------------------------------------------------------
   assign pin_s.event_p = pin_change_evt_i;
   assign pin_s.wake_en = pin_change_wake_en_i;
   assign pin_s.irq_en = pin_change_irq_en_i;
   assign pin_s.wake_ok = low_pwr;
   // in sleep/idle only a wake can start a vector, hence the gating
   assign pin_s.irq_ok = green | normal | (low_pwr & pin_change_wake_en_i);

   assign twi_s.event_p = twowire_evt_i;
   assign twi_s.wake_en = twowire_wake_en_i;
   assign twi_s.irq_en = twowire_irq_en_i;
   assign twi_s.wake_ok = low_pwr & twowire_slave_i;
   // port is unusable in green mode, so it never interrupts there
   assign twi_s.irq_ok = normal | (low_pwr & twowire_wake_en_i & twowire_slave_i);

   assign spi_s.event_p = serial_periph_evt_i;
   assign spi_s.wake_en = serial_periph_wake_en_i;
   assign spi_s.irq_en = serial_periph_irq_en_i;
   assign spi_s.wake_ok = low_pwr & serial_periph_slave_i;
   assign spi_s.irq_ok = green | normal |
      (low_pwr & serial_periph_wake_en_i & serial_periph_slave_i);

   wid_src_dec u_pin (.s(pin_s));
   wid_src_dec u_twi (.s(twi_s));
   wid_src_dec u_spi (.s(spi_s));

   // both enables at 0 leave the source inert in every mode
   assign wake_v[`WID_SRC_PIN] = pin_s.wake;
   assign wake_v[`WID_SRC_TWI] = twi_s.wake;
   assign wake_v[`WID_SRC_SPI] = spi_s.wake;
   assign irq_v[`WID_SRC_PIN] = pin_s.irq;
   assign irq_v[`WID_SRC_TWI] = twi_s.irq;
   assign irq_v[`WID_SRC_SPI] = spi_s.irq;
   assign any_wake = |wake_v;
   assign any_irq = |irq_v;
   assign nxt_vec = any_irq & global_irq_enabled_i;
   assign nxt_src = irq_v;

   // ----------------------------------------------------------------
   // action decision, watchdog has top priority
   // ----------------------------------------------------------------
   always_comb begin
      if (watchdog_timeout_i) begin
         nxt_action = WID_RESET;
      end else if (nxt_vec) begin
         nxt_action = WID_VECTOR;
      end else if (any_wake | any_irq) begin
         nxt_action = WID_RESUME;
      end else begin
         nxt_action = WID_NONE;
      end
   end

   // ----------------------------------------------------------------
   // next values of the one-cycle outputs
   // ----------------------------------------------------------------
   // a reset request swallows any wake seen in the same cycle
   assign nxt_wake = any_wake & ~watchdog_timeout_i;
   assign nxt_resume = (nxt_action == WID_RESUME);
   assign nxt_reset = watchdog_timeout_i;

   // ----------------------------------------------------------------
   // registered outputs, one flop group per concern
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         action_ff <= WID_NONE;
      end else begin
         action_ff <= nxt_action;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= nxt_wake;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         resume_ff <= 1'b0;
      end else begin
         resume_ff <= nxt_resume;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reset_ff <= 1'b0;
      end else begin
         reset_ff <= nxt_reset;
      end
   end

   // vector request holds until the core acknowledges or the watchdog times out; a new request wins over an ack, the watchdog over both
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         vector_req_ff <= 1'b0;
         vector_src_ff <= '0;
      end else if (watchdog_timeout_i) begin
         vector_req_ff <= 1'b0;
         vector_src_ff <= '0;
      end else if (nxt_vec) begin
         vector_req_ff <= 1'b1;
         vector_src_ff <= vector_src_ff & ~{`WID_NSRC{vector_ack_i}} | nxt_src;
      end else if (vector_ack_i) begin
         vector_req_ff <= 1'b0;
         vector_src_ff <= '0;
      end
   end

   assign wake_o = wake_ff;
   assign resume_o = resume_ff;
   assign reset_req_o = reset_ff;
   assign vector_req_o = vector_req_ff;
   assign vector_src_o = vector_src_ff;
   assign action_o = action_ff;
endmodule

/* File: src/wid_pkg.sv */
// types for the wake-up and interrupt dispatch block
package wid_pkg;
   typedef enum logic [3:0] {
      WID_SLEEP = 4'h1,
      WID_IDLE = 4'h2,
      WID_GREEN = 4'h4,
      WID_NORMAL = 4'h8
   } wid_mode_t;
   typedef enum logic [3:0] {
      WID_NONE = 4'h1,
      WID_RESUME = 4'h2,
      WID_VECTOR = 4'h4,
      WID_RESET = 4'h8
   } wid_action_t;
endpackage

/* File: src/wid_src_dec.sv */
// per-source wake and interrupt qualifier
`timescale 1ns/1ns
module wid_src_dec (
   wid_src_if.dec s
);
   // wake needs the wake enable and a mode/role where wake is legal
   assign s.wake = s.event_p & s.wake_en & s.wake_ok;
   // interrupt needs its enable and a mode where the source may interrupt
   assign s.irq = s.event_p & s.irq_en & s.irq_ok;
endmodule

/* File: src/wid_src_if.sv */
// per-source event and decision bundle
`timescale 1ns/1ns
interface wid_src_if;
   logic event_p;
   logic wake_en;
   logic irq_en;
   logic wake_ok;
   logic irq_ok;
   logic wake;
   logic irq;
   modport dec (input event_p, wake_en, irq_en, wake_ok, irq_ok, output wake, irq);
   modport top (output event_p, wake_en, irq_en, wake_ok, irq_ok, input wake, irq);
endinterface

/* File: verification/wid_core_model.sv */
// core stand-in: acks a vector request at once or after a stall
`timescale 1ns/1ns
module wid_core_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // vector handshake and stall select
   input wire logic req_i,
   input wire logic slow_i,
   output logic ack_o
);
   logic [2:0] wait_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_ff <= 3'h0;
         ack_o <= 1'b0;
      end else begin
         ack_o <= req_i && !ack_o && (!slow_i || wait_ff[2]);
         wait_ff <= req_i && !ack_o ? wait_ff + 3'h1 : 3'h0;
      end
   end
endmodule

/* File: verification/wid_dispatch_bench.sv */
// self-checking bench for the dispatch block
`timescale 1ns/1ns
module wid_dispatch_bench;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sl = 1'b0;
   logic ack, req, wake_o, rsm, rrq;
   logic [3:0] act;
   logic [2:0] src;
   logic [19:0] st = 20'h08000;
   logic [1:0] sv = 2'h3;
   int num_errors = 0;
   int cmp_count = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   wid_dispatch dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .power_mode_i(st[15:12]),
      .global_irq_enabled_i(st[16]), .pin_change_evt_i(st[8]), .twowire_evt_i(st[9]),
      .serial_periph_evt_i(st[10]), .watchdog_timeout_i(st[11]), .pin_change_wake_en_i(st[4]),
      .twowire_wake_en_i(st[5]), .serial_periph_wake_en_i(st[6]), .pin_change_irq_en_i(st[0]),
      .twowire_irq_en_i(st[1]), .serial_periph_irq_en_i(st[2]), .twowire_slave_i(sv[0]),
      .serial_periph_slave_i(sv[1]), .vector_ack_i(ack), .wake_o(wake_o), .resume_o(rsm),
      .vector_req_o(req), .vector_src_o(src), .reset_req_o(rrq), .action_o(act));
   wid_core_model core (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .req_i(req), .slow_i(sl),
      .ack_o(ack));
   task automatic final_report();
      if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // nibbles: global, mode, event, wake en, irq en, expected wake, expected action
   task automatic chk(input logic [27:0] v);
      @(posedge sys_clk_i);
      st <= v[27:8];
      @(posedge sys_clk_i);
      st[11:8] <= 4'h0;
      #1;
      cmp_count++;
      if ({rsm, rrq, wake_o, act} !== {v[3:0] == 4'h2, v[3:0] == 4'h8, v[4:0]}) begin
         num_errors++;
         $display("unexpected %0t got %h exp %h", $time, {rsm, rrq, wake_o, act},
            {v[3:0] == 4'h2, v[3:0] == 4'h8, v[4:0]});
      end
      if (v[3:0] == 4'h4 && {req, src} !== {1'b1, v[18:16]}) begin
         num_errors++;
         $display("unexpected %0t got %h exp %h", $time, {req, src}, {1'b1, v[18:16]});
      end
   endtask
   initial begin
      repeat (3) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      chk(28'h0111012);
      chk(28'h1811001);
      chk(28'h1211114);
      chk(28'h0411102);
      chk(28'h1233314);
      chk(28'h1820001);
      chk(28'h0820202);
      chk(28'h1422201);
      chk(28'h1122012);
      chk(28'h1822001);
      @(posedge sys_clk_i);
      sl <= 1'b1;
      chk(28'h1222214);
      chk(28'h1440001);
      chk(28'h1140401);
      chk(28'h1440404);
      chk(28'h0244012);
      chk(28'h1444001);
      chk(28'h0144412);
      chk(28'h1844404);
      @(posedge sys_clk_i);
      sv <= 2'h0;
      chk(28'h1127701);
      chk(28'h1247701);
      @(posedge sys_clk_i);
      sv <= 2'h3;
      for (int i = 0; i < 8; i++) chk({3'h0, i[2], 4'h1 << i[1:0], 20'h87708});
      final_report();
   end
   initial begin
      #20000;
      num_errors++;
      final_report();
   end
endmodule
bind wid_dispatch wid_dispatch_chk watch (.*);

/* File: verification/wid_dispatch_chk.sv */
// port assertions for the dispatch block
`timescale 1ns/1ns
module wid_dispatch_chk (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // core state and sources
   input wire logic [3:0] power_mode_i,
   input wire logic global_irq_enabled_i,
   input wire logic watchdog_timeout_i,
   input wire logic pin_change_evt_i,
   input wire logic pin_change_wake_en_i,
   input wire logic pin_change_irq_en_i,
   input wire logic twowire_evt_i,
   input wire logic twowire_slave_i,
   input wire logic serial_periph_evt_i,
   input wire logic serial_periph_slave_i,
   // sequencer side
   input wire logic vector_ack_i,
   input wire logic wake_o,
   input wire logic resume_o,
   input wire logic vector_req_o,
   input wire logic [2:0] vector_src_o,
   input wire logic reset_req_o,
   input wire logic [3:0] action_o
);
   wire logic lo = power_mode_i == 4'h1 || power_mode_i == 4'h2;
   wire logic pw = pin_change_evt_i && pin_change_wake_en_i && lo && !watchdog_timeout_i;
   wire logic [3:0] ev = {pin_change_evt_i, twowire_evt_i, serial_periph_evt_i, watchdog_timeout_i};
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence held_s; vector_req_o && !vector_ack_i && ev == 4'h0; endsequence
   wdog_reset_a: assert property (watchdog_timeout_i |=> reset_req_o && !vector_req_o)
      else $error("no reset");
   pin_wake_a: assert property (pw |=> wake_o) else $error("no wake");
   wake_resume_a: assert property (pw && !global_irq_enabled_i |=> resume_o)
      else $error("no resume");
   wake_vector_a: assert property (pw && pin_change_irq_en_i && global_irq_enabled_i
      |=> vector_src_o[0]) else $error("no vector");
   twi_master_a: assert property ($onehot(ev) && twowire_evt_i && lo && !twowire_slave_i
      |=> !wake_o) else $error("master wake");
   spi_master_a: assert property ($onehot(ev) && serial_periph_evt_i && lo
      && !serial_periph_slave_i |=> !wake_o) else $error("master wake");
   twi_green_a: assert property ($onehot(ev) && twowire_evt_i && power_mode_i == 4'h4
      |=> action_o == 4'h1) else $error("green action");
   req_hold_a: assert property (held_s |=> vector_req_o && $stable(vector_src_o))
      else $error("request lost");
endmodule
